// ==== design/scan_config_register_bank.sv ====
// scan configuration register bank with measurement sequencer and alarm gating
`timescale 1ns/1ps
`default_nettype none
`include "scan_config_defines.svh"

module scan_config_register_bank
    import scan_config_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   resetn,
    // register port
    input  wire logic [7:0]             regAddr,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    input  wire logic [15:0]            regWdata,
    output logic [15:0]                 regRdata,
    // converter
    output logic                        adcStart,
    output logic [3:0]                  adcChannel,
    input  wire logic                   adcDone,
    input  wire logic [11:0]            adcData,
    output logic                        thermistorBiasPin,
    output logic                        scanBusy,
    // results
    output logic                        resultWrite,
    output logic [3:0]                  resultChannel,
    output logic [11:0]                 resultData,
    input  wire logic [3:0]             cellReadIndex,
    output logic [11:0]                 cellReadData,
    // alerts and alarm
    input  wire logic [`CELL_COUNT-1:0] cellOverLimit,
    input  wire logic                   mismatchAlertFlag,
    input  wire logic                   undervoltageAlertFlag,
    input  wire logic                   coldAlertFlag,
    input  wire logic                   hotAlertFlag,
    input  wire logic                   packetCheckAlertFlag,
    input  wire logic                   nackAlertFlag,
    output logic                        overvoltageAlertFlag,
    output logic                        alarmOut,
    // pins and balancing
    output logic [1:0]                  pinOutputEnable,
    input  wire logic                   dieOverTemp,
    input  wire logic                   balanceWatchdog,
    output logic [`CELL_COUNT-1:0]      dischargeSwitch
);

    // ========================================================================
    // register storage
    logic [14:0]              alarmConfig;
    logic [`CELL_COUNT-1:0]   cellScanEnable;
    logic [15:0]              pinControl;
    logic [`CELL_COUNT-1:0]   balanceBits;
    logic [`SETTLE_WIDTH-1:0] auxSettleCount;
    logic                     scanRequest;
    logic [15:0]              next_regRdata;

    assign scanRequest = regWrite &&
        ((regAddr == `REG_SCAN_TRIGGER_CONTROL && regWdata[`SCAN_TRIGGER_BIT]) ||
         (regAddr == `REG_CONVERTER_ALARM_CONFIG && regWdata[`ALT_TRIGGER_BIT]));

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alarmConfig    <= `ALARM_CONFIG_RESET;
            cellScanEnable <= `CELL_ENABLE_RESET;
            pinControl     <= `PIN_CONTROL_RESET;
            balanceBits    <= `BALANCE_RESET;
            auxSettleCount <= `SETTLE_RESET;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `REG_CONVERTER_ALARM_CONFIG: alarmConfig <= regWdata[14:0];
                `REG_CELL_SCAN_ENABLE:       cellScanEnable <= regWdata[11:0];
                `REG_GENERAL_PIN_CONTROL:    pinControl <= regWdata;
                `REG_BALANCING_SWITCH:       balanceBits <= regWdata[11:0];
                `REG_ACQUISITION_TIMING:     auxSettleCount <= regWdata[5:0];
                default:                     ;
            endcase
        end
    end

    // trigger bits and reserved bits always read as zero
    always_comb
    begin
        next_regRdata = 16'h0000;
        case (regAddr)
            `REG_CONVERTER_ALARM_CONFIG: next_regRdata = {1'b0, alarmConfig};
            `REG_CELL_SCAN_ENABLE:       next_regRdata = {4'h0, cellScanEnable};
            `REG_GENERAL_PIN_CONTROL:    next_regRdata = pinControl;
            `REG_BALANCING_SWITCH:       next_regRdata = {4'h0, balanceBits};
            `REG_ACQUISITION_TIMING:     next_regRdata = {10'h000, auxSettleCount};
            default:                     next_regRdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            regRdata <= 16'h0000;
        else if (regRead)
            regRdata <= next_regRdata;
    end

    // ========================================================================
    // measurement sequencer
    seq_state_t             seqState;
    logic [3:0]             cellIndex;
    logic [`CELL_COUNT-1:0] scanCells;
    logic                   scanSelfTest;
    logic [1:0]             scanAux;
    logic                   auxIndex;
    logic                   settleStart;
    logic                   settleDone;
    logic [11:0]            cellResult [`CELL_COUNT];

    aux_settle_timer settleTimer
    (
        .clk    (clk),
        .resetn (resetn),
        .start  (settleStart),
        .code   (auxSettleCount),
        .done   (settleDone)
    );

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            seqState          <= SEQ_IDLE;
            cellIndex         <= 4'h0;
            scanCells         <= 12'h000;
            scanSelfTest      <= 1'b0;
            scanAux           <= 2'b00;
            auxIndex          <= 1'b0;
            settleStart       <= 1'b0;
            adcStart          <= 1'b0;
            adcChannel        <= 4'h0;
            thermistorBiasPin <= 1'b0;
        end
        else
        begin
            adcStart    <= 1'b0;
            settleStart <= 1'b0;
            case (seqState)
                SEQ_IDLE:
                begin
                    // requests arriving in any other state fall through unseen
                    if (scanRequest)
                    begin
                        scanCells    <= cellScanEnable;
                        scanSelfTest <= alarmConfig[`SELF_TEST_BIT];
                        scanAux      <= {alarmConfig[`AUX_TWO_BIT],
                                         alarmConfig[`AUX_ONE_BIT]};
                        cellIndex    <= 4'h0;
                        seqState     <= SEQ_CELL_PICK;
                    end
                end
                SEQ_CELL_PICK:
                begin
                    if (cellIndex == 4'(`CELL_COUNT))
                        seqState <= SEQ_SELF_TEST;
                    else if (scanCells[cellIndex])
                    begin
                        adcStart   <= 1'b1;
                        adcChannel <= cellIndex;
                        seqState   <= SEQ_CONV_WAIT;
                    end
                    else
                        cellIndex <= cellIndex + 4'h1;
                end
                SEQ_CONV_WAIT:
                begin
                    if (adcDone)
                    begin
                        if (adcChannel < 4'(`CELL_COUNT))
                        begin
                            cellIndex <= cellIndex + 4'h1;
                            seqState  <= SEQ_CELL_PICK;
                        end
                        else if (adcChannel == `CH_SELF_TEST)
                        begin
                            auxIndex <= 1'b0;
                            seqState <= SEQ_AUX_PICK;
                        end
                        else if (adcChannel == `CH_AUX_ONE)
                        begin
                            auxIndex <= 1'b1;
                            seqState <= SEQ_AUX_PICK;
                        end
                        else
                        begin
                            thermistorBiasPin <= 1'b0;
                            seqState          <= SEQ_IDLE;
                        end
                    end
                end
                SEQ_SELF_TEST:
                begin
                    if (scanSelfTest)
                    begin
                        adcStart   <= 1'b1;
                        adcChannel <= `CH_SELF_TEST;
                        seqState   <= SEQ_CONV_WAIT;
                    end
                    else
                    begin
                        auxIndex <= 1'b0;
                        seqState <= SEQ_AUX_PICK;
                    end
                end
                SEQ_AUX_PICK:
                begin
                    if (scanAux[auxIndex])
                    begin
                        // thermistor bias runs only while auxiliary inputs are measured
                        thermistorBiasPin <= 1'b1;
                        settleStart       <= 1'b1;
                        seqState          <= SEQ_AUX_SETTLE;
                    end
                    else if (!auxIndex)
                        auxIndex <= 1'b1;
                    else
                    begin
                        thermistorBiasPin <= 1'b0;
                        seqState          <= SEQ_IDLE;
                    end
                end
                SEQ_AUX_SETTLE:
                begin
                    if (settleDone)
                    begin
                        adcStart   <= 1'b1;
                        adcChannel <= auxIndex ? `CH_AUX_TWO : `CH_AUX_ONE;
                        seqState   <= SEQ_CONV_WAIT;
                    end
                end
                default: seqState <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            scanBusy <= 1'b0;
        else
            scanBusy <= (seqState == SEQ_IDLE) ? scanRequest : !(seqState == SEQ_CONV_WAIT
                && adcDone && adcChannel == `CH_AUX_TWO) && !(seqState == SEQ_AUX_PICK
                && auxIndex && !scanAux[1]);
    end

    // ========================================================================
    // results: only converted channels are written
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            resultWrite   <= 1'b0;
            resultChannel <= 4'h0;
            resultData    <= 12'h000;
            cellReadData  <= 12'h000;
        end
        else
        begin
            resultWrite <= seqState == SEQ_CONV_WAIT && adcDone;
            if (seqState == SEQ_CONV_WAIT && adcDone)
            begin
                resultChannel <= adcChannel;
                resultData    <= adcData;
            end
            cellReadData <= (cellReadIndex < 4'(`CELL_COUNT)) ? cellResult[cellReadIndex]
                                                              : 12'h000;
        end
    end

    // result store is plain memory, left without reset to map onto an array
    always_ff @(posedge clk)
    begin
        if (seqState == SEQ_CONV_WAIT && adcDone && adcChannel < 4'(`CELL_COUNT))
            cellResult[adcChannel] <= adcData;
    end

    // ========================================================================
    // alarm gating
    logic [6:0] alertFlags;
    logic       next_overvoltage;

    assign next_overvoltage = |(cellOverLimit & cellScanEnable);
    assign alertFlags = {mismatchAlertFlag, next_overvoltage, undervoltageAlertFlag,
                         coldAlertFlag, hotAlertFlag, packetCheckAlertFlag, nackAlertFlag};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            overvoltageAlertFlag <= 1'b0;
            alarmOut             <= 1'b0;
        end
        else
        begin
            overvoltageAlertFlag <= next_overvoltage;
            alarmOut <= |(alertFlags & alarmConfig[14:8]);
        end
    end

    // ========================================================================
    // pin direction and balancing switches
    logic [2:0] hotSync;
    logic [2:0] dogSync;
    logic       balanceOff;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hotSync    <= 3'b000;
            dogSync    <= 3'b000;
            balanceOff <= 1'b0;
        end
        else
        begin
            hotSync <= {hotSync[1:0], dieOverTemp};
            dogSync <= {dogSync[1:0], balanceWatchdog};
            // a change is accepted only once the last two stages agree
            if (hotSync[1] == hotSync[2] && dogSync[1] == dogSync[2])
                balanceOff <= hotSync[2] | dogSync[2];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dischargeSwitch <= 12'h000;
            pinOutputEnable <= 2'b00;
        end
        else
        begin
            dischargeSwitch <= balanceOff ? 12'h000 : balanceBits;
            pinOutputEnable <= {pinControl[`PIN_TWO_DIR_BIT],
                                pinControl[`PIN_ONE_DIR_BIT]};
        end
    end

    // ========================================================================
    // checks
    sequence auxSettled;
        seqState == SEQ_AUX_SETTLE && settleDone;
    endsequence

    sequence auxLaunched;
        adcStart && adcChannel >= `CH_AUX_ONE;
    endsequence

    chk_trigger_starts_scan: assert property (@(posedge clk) disable iff (!resetn)
        seqState == SEQ_IDLE && scanRequest |=> scanBusy && seqState == SEQ_CELL_PICK)
        else $error("scan trigger did not start a scan");

    chk_busy_request_dropped: assert property (@(posedge clk) disable iff (!resetn)
        seqState != SEQ_IDLE && scanRequest |=> $stable(scanCells))
        else $error("request during scan was acted on");

    chk_trigger_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
        regRead && regAddr == `REG_SCAN_TRIGGER_CONTROL |=> regRdata == 16'h0000)
        else $error("scan control read nonzero");

    chk_alt_trigger_zero: assert property (@(posedge clk) disable iff (!resetn)
        regRead && regAddr == `REG_CONVERTER_ALARM_CONFIG |=> !regRdata[15])
        else $error("alternate trigger bit read as one");

    chk_alarm_mask_gate: assert property (@(posedge clk) disable iff (!resetn)
        ##1 alarmOut == |($past(alertFlags) & $past(alarmConfig[14:8])))
        else $error("alarm does not follow masked alerts");

    chk_disabled_cell_kept: assert property (@(posedge clk) disable iff (!resetn)
        resultWrite && resultChannel < 4'(`CELL_COUNT) |-> scanCells[resultChannel])
        else $error("disabled cell result written");

    chk_balance_forced_open: assert property (@(posedge clk) disable iff (!resetn)
        balanceOff |=> dischargeSwitch == 12'h000)
        else $error("switch closed during balancing disable");

    chk_balance_follow: assert property (@(posedge clk) disable iff (!resetn)
        !balanceOff |=> dischargeSwitch == $past(balanceBits))
        else $error("switch does not follow balancing bits");

    chk_settle_before_aux: assert property (@(posedge clk) disable iff (!resetn)
        auxSettled |=> auxLaunched)
        else $error("auxiliary conversion not launched after settle");

    chk_aux_after_settle: assert property (@(posedge clk) disable iff (!resetn)
        auxLaunched |-> $past(settleDone))
        else $error("auxiliary conversion without settling");

    chk_pin_direction: assert property (@(posedge clk) disable iff (!resetn)
        ##1 pinOutputEnable[1] == $past(pinControl[`PIN_TWO_DIR_BIT])
            && pinOutputEnable[0] == $past(pinControl[`PIN_ONE_DIR_BIT]))
        else $error("pin driver enable mismatch");

endmodule
`default_nettype wire

// ==== design/scan_config_defines.svh ====
// offsets, field positions, reset values and timing counts of the scan configuration bank
// ============================================================================
// Summary of operation
// - writing one to scan control bit 0 starts one scan of enabled cells
// - a start request while a scan runs is dropped, never queued
// - every scan trigger bit is a strobe and always reads back zero
// - converter config bit 15 is a second trigger behaving exactly like the first
// - config bits 14,13,12 gate mismatch, overvoltage, undervoltage alerts onto the alarm
// - config bits 11 and 10 gate cold and hot alerts onto the alarm
// - config bits 9 and 8 gate packet check and nack alerts onto the alarm
// - unused config bits 7,6,5,3,2 are plain read/write storage
// - config bit 4 adds a reference self-test conversion to each scan
// - config bits 1 and 0 enable conversion of auxiliary inputs two and one
// - cell enable bits 11..0 include cells twelve..one in the scan
// - a scan leaves results of disabled cells untouched
// - reserved bits and non-trigger scan control bits ignore writes, read zero
// - pin direction bits 14,13 enable pin drivers when one; reset to zero
// - balancing bit N closes the discharge switch across cell N
// - die overtemperature or balancing watchdog forces every switch open
// - six-bit settle field sets auxiliary settling in 5.3 us steps up to 339.2 us
// - settle field resets to zero, the 5.3 us minimum
// - the full settle interval precedes every enabled auxiliary conversion
// - overvoltage flag is set while any enabled cell exceeds its limit
`ifndef SCAN_CONFIG_DEFINES_SVH
`define SCAN_CONFIG_DEFINES_SVH

// ============================================================================
// register offsets
`define REG_CONVERTER_ALARM_CONFIG 8'h08
`define REG_CELL_SCAN_ENABLE       8'h09
`define REG_GENERAL_PIN_CONTROL    8'h0a
`define REG_BALANCING_SWITCH       8'h0b
`define REG_ACQUISITION_TIMING     8'h0c
`define REG_SCAN_TRIGGER_CONTROL   8'h0d

// ============================================================================
// field positions
`define SCAN_TRIGGER_BIT   0
`define ALT_TRIGGER_BIT    15
`define MISMATCH_MASK_BIT  14
`define OVER_V_MASK_BIT    13
`define UNDER_V_MASK_BIT   12
`define COLD_MASK_BIT      11
`define HOT_MASK_BIT       10
`define PACKET_MASK_BIT    9
`define NACK_MASK_BIT      8
`define SELF_TEST_BIT      4
`define AUX_TWO_BIT        1
`define AUX_ONE_BIT        0
`define PIN_TWO_DIR_BIT    14
`define PIN_ONE_DIR_BIT    13
`define CELL_COUNT         12
`define SETTLE_WIDTH       6

// ============================================================================
// reset values
`define ALARM_CONFIG_RESET 15'h0000
`define CELL_ENABLE_RESET  12'h000
`define PIN_CONTROL_RESET  16'h0000
`define BALANCE_RESET      12'h000
`define SETTLE_RESET       6'h00

// ============================================================================
// converter channel codes
`define CH_SELF_TEST 4'hc
`define CH_AUX_ONE   4'hd
`define CH_AUX_TWO   4'he

// ============================================================================
// timing
`define CLK_PERIOD_PS       25000
`define AUX_SETTLE_STEP_PS  5300000
`define AUX_SETTLE_MAX_PS   339200000
`define AUX_SETTLE_STEP_CYC ((`AUX_SETTLE_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== design/scan_config_pkg.sv ====
// types shared by the scan configuration bank
package scan_config_pkg;

    typedef enum logic [2:0]
    {
        SEQ_IDLE,
        SEQ_CELL_PICK,
        SEQ_CONV_WAIT,
        SEQ_SELF_TEST,
        SEQ_AUX_PICK,
        SEQ_AUX_SETTLE
    } seq_state_t;

endpackage

// ==== design/aux_settle_timer.sv ====
// auxiliary input settling timer
`timescale 1ns/1ps
`default_nettype none
`include "scan_config_defines.svh"

module aux_settle_timer
    import scan_config_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // control
    input  wire logic                     start,
    input  wire logic [`SETTLE_WIDTH-1:0] code,
    // status
    output logic                          done
);

    localparam int STEP = `AUX_SETTLE_STEP_CYC;

    logic [13:0] remaining;
    logic        running;
    logic [13:0] loadValue;

    // code zero is one step, code 63 is 64 steps
    assign loadValue = 14'((int'(code) + 1) * STEP - 1);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            remaining <= 14'h0000;
            running   <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                remaining <= loadValue;
                running   <= 1'b1;
            end
            else if (running)
            begin
                if (remaining == 14'h0000)
                begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                else
                begin
                    remaining <= remaining - 14'h0001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/adc_model.sv ====
// converter stand-in answering each start after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module adc_model #(parameter int DELAY = 5)
(
    // clock
    input  wire logic        clk,
    // converter
    input  wire logic        adcStart,
    input  wire logic [3:0]  adcChannel,
    input  wire logic [7:0]  dataBase,
    output logic             adcDone = 1'b0,
    output logic [11:0]      adcData = 12'h5a5
);
    int cnt = 0;
    logic [3:0] ch = 4'h0;
    always_ff @(posedge clk)
    begin
        adcDone <= 1'b0;
        // data wanders outside the done cycle so stale reads show
        adcData <= ~adcData;
        if (adcStart)
        begin
            cnt <= DELAY;
            ch <= adcChannel;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
        else if (cnt == 1)
        begin
            cnt <= 0;
            adcDone <= 1'b1;
            adcData <= {dataBase, ch};
        end
    end
endmodule
`default_nettype wire

// ==== verification/test_scan_config_register_bank.sv ====
// self-checking bench for the scan configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_scan_config_register_bank;
    logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic dieOverTemp = 1'b0, balanceWatchdog = 1'b0;
    logic [7:0] regAddr = 8'h00, dataBase = 8'h10;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic [15:0] ev[7] = '{16'h7fff, 16'h0fff, 16'hffff, 16'h0fff, 16'h003f, 0, 0};
    logic [3:0] cellReadIndex = 4'h0, adcChannel, resultChannel;
    logic [11:0] cellOverLimit = 12'h000, adcData, resultData, cellReadData, dischargeSwitch;
    logic [5:0] alerts = 6'h00;
    logic [1:0] pinOutputEnable;
    logic adcStart, adcDone, scanBusy, resultWrite, overvoltageAlertFlag, alarmOut;
    logic thermistorBiasPin;
    wire mismatchAlertFlag, undervoltageAlertFlag, coldAlertFlag, hotAlertFlag;
    wire packetCheckAlertFlag, nackAlertFlag;
    logic [3:0] seen[$];
    int n_mismatch = 0, n_tests = 0, cyc;
    assign {mismatchAlertFlag, undervoltageAlertFlag, coldAlertFlag, hotAlertFlag,
        packetCheckAlertFlag, nackAlertFlag} = alerts;
    scan_config_register_bank scan_config_register_bank_i (.clk, .resetn, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata, .adcStart, .adcChannel, .adcDone, .adcData,
        .thermistorBiasPin, .scanBusy, .resultWrite, .resultChannel, .resultData,
        .cellReadIndex, .cellReadData, .cellOverLimit, .mismatchAlertFlag,
        .undervoltageAlertFlag, .coldAlertFlag, .hotAlertFlag, .packetCheckAlertFlag,
        .nackAlertFlag, .overvoltageAlertFlag, .alarmOut, .pinOutputEnable, .dieOverTemp,
        .balanceWatchdog, .dischargeSwitch);
    adc_model adc_model_i (.clk, .adcStart, .adcChannel, .dataBase, .adcDone, .adcData);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk)
        if (resultWrite === 1'b1)
        begin
            seen.push_back(resultChannel);
            chk({4'h0, resultData}, {4'h0, dataBase, resultChannel});
        end
    // ====================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        chk(regRdata, exp);
    endtask
    task automatic cellchk(input logic [3:0] i, input logic [11:0] exp);
        cellReadIndex = i;
        repeat (2) @(negedge clk);
        chk({4'h0, cellReadData}, {4'h0, exp});
    endtask
    task automatic seqchk(input int n, input logic [15:0] e);
        chk(16'(seen.size()), 16'(n));
        for (int i = 0; i < n && i < seen.size(); i++) chk({12'h0, seen[i]}, {12'h0, e[4*i+:4]});
        seen.delete();
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_idle;
        cyc = 2;
        repeat (2) @(negedge clk);
        while (scanBusy !== 1'b0 && cyc < 20000)
        begin
            @(negedge clk);
            cyc++;
        end
        // when auxiliary two ends a scan, its result is written on the edge where busy falls
        @(negedge clk);
        if (scanBusy !== 1'b0)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // ====================
    // tests
    initial
    begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        for (int a = 8; a < 15; a++) rdchk(8'(a), 16'h0000);
        for (int k = 0; k < 7; k++)
        begin
            wr(8'(k + 8), k == 0 ? 16'h7fff : k == 5 ? 16'hfffe : 16'hffff);
            rdchk(8'(k + 8), ev[k]);
        end
        chk({4'h0, dischargeSwitch}, 16'h0fff);
        chk({14'h0, pinOutputEnable}, 16'h0003);
        for (int k = 3; k >= 0; k--)
        begin
            {dieOverTemp, balanceWatchdog} = 2'(k);
            repeat (8) @(negedge clk);
            chk({4'h0, dischargeSwitch}, k == 0 ? 16'h0fff : 16'h0000);
        end
        $display("test registers done");
        for (int k = 0; k < 6; k++)
        begin
            wr(8'h08, 16'h0100 << (k + (k == 5)));
            alerts = ~(6'h01 << k);
            repeat (3) @(negedge clk);
            chk({15'h0, alarmOut}, 16'h0000);
            alerts = 6'h01 << k;
            repeat (3) @(negedge clk);
            chk({15'h0, alarmOut}, 16'h0001);
        end
        alerts = 6'h00;
        wr(8'h08, 16'h2000);
        wr(8'h09, 16'h0001);
        cellOverLimit = 12'h002;
        repeat (3) @(negedge clk);
        chk({14'h0, overvoltageAlertFlag, alarmOut}, 16'h0000);
        cellOverLimit = 12'h001;
        repeat (3) @(negedge clk);
        chk({14'h0, overvoltageAlertFlag, alarmOut}, 16'h0003);
        cellOverLimit = 12'h000;
        $display("test alarm done");
        wr(8'h08, 16'h0000);
        wr(8'h09, 16'h0805);
        wr(8'h0c, 16'h0000);
        seen.delete();
        wr(8'h0d, 16'h0001);
        wr(8'h0d, 16'h0001);
        wait_idle();
        seqchk(3, 16'h0b20);
        dataBase = 8'h20;
        wr(8'h09, 16'h0001);
        // the trigger snapshots the enables stored before its own write
        wr(8'h08, 16'h0011);
        wr(8'h08, 16'h8011);
        repeat (100) @(negedge clk);
        chk({15'h0, thermistorBiasPin}, 16'h0001);
        wait_idle();
        seqchk(3, 16'h0dc0);
        chk({15'h0, thermistorBiasPin}, 16'h0000);
        cellchk(4'h0, 12'h200);
        cellchk(4'h2, 12'h102);
        rdchk(8'h08, 16'h0011);
        wr(8'h09, 16'h0000);
        wr(8'h0c, 16'h0001);
        wr(8'h08, 16'h0003);
        wr(8'h0d, 16'h0001);
        wait_idle();
        seqchk(2, 16'h00ed);
        chk(16'(cyc >= 848 && cyc < 920), 16'h0001);
        $display("test scans done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
